// ===== flash_host_defines.svh
// Command codes, unlock offsets and timing counts for the flash command host.
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH
`define ADDR_W 23
`define DATA_W 16
`define UNLOCK_ADDR1 12'h555
`define UNLOCK_ADDR2 12'h2aa
`define UNLOCK_DATA1 8'haa
`define UNLOCK_DATA2 8'h55
`define CMD_RESET 8'hf0
`define CMD_AUTOSEL 8'h90
`define CMD_PROGRAM 8'ha0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_CFI 8'h98
`define CFI_ADDR 12'h055
`define CMD_BYPASS 8'h20
`define CMD_BYPASS_EXIT 8'h00
`define AS_MANUF 8'h00
`define AS_DEVID 8'h01
`define AS_PROTECT 8'h02
`define AS_SECURE 8'h03
`define AS_DEVID2 8'h0e
`define AS_DEVID3 8'h0f
`define SECTOR_LSB 12
`define BANK_LSB 20
`define ERASE_WINDOW_NS 50000
`define SUSPEND_LAT_NS 35000
`define CLK_NS 100
`define ERASE_WINDOW_CYC (`ERASE_WINDOW_NS / `CLK_NS)
`define SUSPEND_LAT_CYC ((`SUSPEND_LAT_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_CYC 3
`endif

// ===== flash_host_pkg.sv
// Types shared by the flash command host.
package flash_host_pkg;
	typedef enum logic [3:0]
	{
		OP_READ = 4'h0,
		OP_RESET = 4'h1,
		OP_AUTOSEL = 4'h2,
		OP_PROGRAM = 4'h3,
		OP_CHIP_ERASE = 4'h4,
		OP_SECTOR_ERASE = 4'h5,
		OP_SUSPEND = 4'h6,
		OP_RESUME = 4'h7,
		OP_CFI = 4'h8,
		OP_BYPASS_ENTER = 4'h9,
		OP_BYPASS_PROGRAM = 4'ha,
		OP_BYPASS_ERASE = 4'hb,
		OP_BYPASS_EXIT = 4'hc,
		OP_AUTOSEL_READ = 4'hd,
		OP_SECTOR_ADD = 4'he
	} op_t;
	typedef enum logic [1:0]
	{
		CYC_IDLE = 2'h0,
		CYC_SETUP = 2'h1,
		CYC_STROBE = 2'h2,
		CYC_HOLD = 2'h3
	} cyc_state_t;
endpackage

// ===== flash_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, timed from the host clock.
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_defines.svh"
module flash_bus_cycle
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Cycle request.
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [`ADDR_W-1:0] addr_i,
	input wire logic [`DATA_W-1:0] wdata_i,
	output logic done_o,
	output logic [`DATA_W-1:0] rdata_o,
	// Flash pins.
	output logic [`ADDR_W-1:0] addr_o,
	output logic [`DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	input wire logic [`DATA_W-1:0] dq_i,
	output logic chip_sel_n_o,
	output logic write_n_o,
	output logic read_n_o
);
	flash_host_pkg::cyc_state_t st_r, st_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic wr_r, wr_nxt;
	logic done_r, done_nxt;
	logic [`ADDR_W-1:0] addr_r, addr_nxt;
	logic [`DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [`DATA_W-1:0] dq_s1_r, dq_s2_r;

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		rd_nxt = rd_r;
		done_nxt = 1'b0;
		case (st_r)
			flash_host_pkg::CYC_IDLE:
				if (start_i)
				begin
					st_nxt = flash_host_pkg::CYC_SETUP;
					wr_nxt = write_i;
					addr_nxt = addr_i;
					wd_nxt = wdata_i;
				end
			flash_host_pkg::CYC_SETUP:
			begin
				st_nxt = flash_host_pkg::CYC_STROBE;
				cnt_nxt = 2'(`STROBE_CYC);
			end
			flash_host_pkg::CYC_STROBE:
				if (cnt_r == 2'h0)
				begin
					st_nxt = flash_host_pkg::CYC_HOLD;
					// Read data has passed the synchroniser by now.
					rd_nxt = dq_s2_r;
				end
				else
					cnt_nxt = cnt_r - 2'h1;
			default:
			begin
				st_nxt = flash_host_pkg::CYC_IDLE;
				done_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r <= flash_host_pkg::CYC_IDLE;
			cnt_r <= 2'h0;
			wr_r <= 1'b0;
			addr_r <= '0;
			wd_r <= '0;
			rd_r <= '0;
			done_r <= 1'b0;
			dq_s1_r <= '0;
			dq_s2_r <= '0;
			chip_sel_n_o <= 1'b1;
			write_n_o <= 1'b1;
			read_n_o <= 1'b1;
			dq_oe_o <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
			done_r <= done_nxt;
			dq_s1_r <= dq_i;
			dq_s2_r <= dq_s1_r;
			// Address is set up a cycle before the strobe falls and held after it rises.
			chip_sel_n_o <= !(st_nxt != flash_host_pkg::CYC_IDLE);
			write_n_o <= !(wr_nxt && st_nxt == flash_host_pkg::CYC_STROBE);
			read_n_o <= !(!wr_nxt && st_nxt == flash_host_pkg::CYC_STROBE);
			dq_oe_o <= wr_nxt && st_nxt != flash_host_pkg::CYC_IDLE;
		end
	end

	assign addr_o = addr_r;
	assign dq_o = wd_r;
	assign done_o = done_r;
	assign rdata_o = rd_r;
endmodule // flash_bus_cycle
`default_nettype wire

// ===== flash_cmd_host.sv
// Host controller that issues flash command sequences.
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_defines.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1: Program suspend is one B0 write; its address is don't-care.
// RQ2: During program suspend, reads of other sectors return array data.
// RQ3: Program suspend is allowed inside erase suspend.
// RQ4: Host enters and exits the secure region around reads during suspend; the host has no secure-region command.
// RQ5: Autoselect is allowed in program suspend; reset returns to suspend.
// RQ6: Host writes one 30 resume to leave suspend; repeats are ignored.
// RQ7: After resume, a new program suspend may be written.
// RQ8: Array read is one read cycle with no command writes.
// RQ9: One F0 write at any address resets the bank.
// RQ10: Unlock cycles use 555/2AA low address bits and low data byte.
// RQ11: Autoselect: two unlocks, 90 at bank address, then reads.
// RQ12: Host reads identification at X01, X0E, X0F in consecutive reads.
// RQ13: Autoselect X02 at sector address returns protection byte 00h/01h.
// RQ14: Autoselect X03 returns secure lock state in DQ7 and DQ6.
// RQ15: Program is two unlocks, A0, then address and 16-bit data.
// RQ16: Program data latches on first rising strobe, written to address.
// RQ17: Erase is six writes ending 10 at 555 or 30 at sector.
// RQ18: Bank address comes from the top address bits.
// RQ19: B0 with bank address suspends sector erase.
// RQ20: 30 with bank address resumes from erase suspend.
// RQ21: 98 at 55 enters CFI query from read or autoselect.
// RQ22: Bypass: unlocks and 20, then two-write program, erase, exit 90/00.
// RQ23: More sector addresses are accepted within the 50 us window.
// RQ24: Erase suspend takes effect within 35 us of the write.
// RQ25: During sector erase only erase suspend is written.
// RQ26: A mismatched write abandons the sequence in the device.
module flash_cmd_host
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Command request.
	input wire logic req_i,
	input wire logic [3:0] op_i,
	input wire logic [`ADDR_W-1:0] addr_i,
	input wire logic [`DATA_W-1:0] data_i,
	output logic busy_o,
	output logic done_o,
	output logic refused_o,
	output logic [`DATA_W-1:0] rdata_o,
	// Host-side state view.
	output logic erasing_o,
	output logic erase_susp_o,
	output logic prog_susp_o,
	output logic bypass_o,
	output logic window_open_o,
	// Flash pins.
	output logic [`ADDR_W-1:0] flash_addr_o,
	output logic [`DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic [`DATA_W-1:0] flash_dq_i,
	output logic chip_sel_n_o,
	output logic write_n_o,
	output logic read_n_o,
	output logic accelerate_protect_pin_o
);
	localparam int WIN_CYC = `ERASE_WINDOW_CYC;
	localparam int LAT_CYC = `SUSPEND_LAT_CYC;

	typedef enum logic [1:0]
	{
		SEQ_IDLE = 2'h0,
		SEQ_ISSUE = 2'h1,
		SEQ_WAIT = 2'h2,
		SEQ_LATENCY = 2'h3
	} seq_state_t;

	seq_state_t st_r, st_nxt;
	logic [3:0] op_r, op_nxt;
	logic [2:0] step_r, step_nxt;
	logic [`ADDR_W-1:0] a_r, a_nxt;
	logic [`DATA_W-1:0] d_r, d_nxt, rd_r, rd_nxt;
	logic busy_r, busy_nxt, done_r, done_nxt, ref_r, ref_nxt;
	logic erasing_r, erasing_nxt, esusp_r, esusp_nxt, psusp_r, psusp_nxt;
	logic byp_r, byp_nxt;
	logic [9:0] win_r, win_nxt;
	logic [8:0] lat_r, lat_nxt;
	logic win_open_r;
	logic cyc_start, cyc_write, cyc_done;
	logic [`ADDR_W-1:0] cyc_addr;
	logic [`DATA_W-1:0] cyc_wdata, cyc_rdata;
	logic [2:0] n_steps;

	// Keeps the bank bits and forces the low twelve to an unlock offset.
	function automatic logic [`ADDR_W-1:0] unlock_addr(input logic [`ADDR_W-1:0] a,
		input logic [11:0] off);
		unlock_addr = {a[`ADDR_W-1:`BANK_LSB], {(`BANK_LSB-12){1'b0}}, off}; // RQ10 RQ18
	endfunction

	// Address and data of one step of an operation.
	function automatic logic [`ADDR_W+`DATA_W:0] step_word(input logic [3:0] op,
		input logic [2:0] s, input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
		logic [`ADDR_W-1:0] ua;
		logic [7:0] cmd;
		ua = '0;
		cmd = 8'h00;
		case (s)
			3'h0, 3'h3:
			begin
				ua = unlock_addr(a, `UNLOCK_ADDR1);
				cmd = `UNLOCK_DATA1;
			end
			3'h1, 3'h4:
			begin
				ua = unlock_addr(a, `UNLOCK_ADDR2);
				cmd = `UNLOCK_DATA2;
			end
			3'h2:
			begin
				ua = unlock_addr(a, `UNLOCK_ADDR1);
				cmd = (op == 4'(flash_host_pkg::OP_AUTOSEL)) ? `CMD_AUTOSEL :
					(op == 4'(flash_host_pkg::OP_PROGRAM)) ? `CMD_PROGRAM :
					(op == 4'(flash_host_pkg::OP_BYPASS_ENTER)) ? `CMD_BYPASS :
					`CMD_ERASE_SETUP; // RQ11 RQ15 RQ17 RQ22
			end
			default:
			begin
				if (op == 4'(flash_host_pkg::OP_CHIP_ERASE))
				begin
					ua = unlock_addr(a, `UNLOCK_ADDR1);
					cmd = `CMD_CHIP_ERASE; // RQ17
				end
				else
				begin
					ua = {a[`ADDR_W-1:`SECTOR_LSB], {`SECTOR_LSB{1'b0}}};
					cmd = `CMD_SECTOR_ERASE; // RQ17
				end
			end
		endcase
		step_word = {1'b1, ua, 8'h00, cmd};
		if (op == 4'(flash_host_pkg::OP_PROGRAM) && s == 3'h3)
			step_word = {1'b1, a, d}; // RQ15 RQ16
	endfunction

	logic [`ADDR_W+`DATA_W:0] sw;
	logic legal;

	flash_bus_cycle u_cycle
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(cyc_start),
		.write_i(cyc_write),
		.addr_i(cyc_addr),
		.wdata_i(cyc_wdata),
		.done_o(cyc_done),
		.rdata_o(cyc_rdata),
		.addr_o(flash_addr_o),
		.dq_o(flash_dq_o),
		.dq_oe_o(flash_dq_oe_o),
		.dq_i(flash_dq_i),
		.chip_sel_n_o(chip_sel_n_o),
		.write_n_o(write_n_o),
		.read_n_o(read_n_o)
	);

	//////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		// Unlocked sequences have their own step count; single writes take one.
		case (op_r)
			4'(flash_host_pkg::OP_AUTOSEL), 4'(flash_host_pkg::OP_BYPASS_ENTER): n_steps = 3'h3;
			4'(flash_host_pkg::OP_PROGRAM): n_steps = 3'h4;
			4'(flash_host_pkg::OP_CHIP_ERASE), 4'(flash_host_pkg::OP_SECTOR_ERASE): n_steps = 3'h6;
			4'(flash_host_pkg::OP_BYPASS_PROGRAM), 4'(flash_host_pkg::OP_BYPASS_ERASE),
			4'(flash_host_pkg::OP_BYPASS_EXIT): n_steps = 3'h2;
			default: n_steps = 3'h1;
		endcase
		sw = step_word(op_r, step_r, a_r, d_r);
		cyc_write = 1'b1;
		cyc_addr = sw[`ADDR_W+`DATA_W-1:`DATA_W];
		cyc_wdata = sw[`DATA_W-1:0];
		case (op_r)
			4'(flash_host_pkg::OP_READ), 4'(flash_host_pkg::OP_AUTOSEL_READ):
			begin
				cyc_write = 1'b0; // RQ8 RQ12
				cyc_addr = a_r;
			end
			4'(flash_host_pkg::OP_RESET):
				cyc_wdata = {8'h00, `CMD_RESET}; // RQ9
			4'(flash_host_pkg::OP_SUSPEND):
				cyc_wdata = {8'h00, `CMD_SUSPEND}; // RQ1 RQ19
			4'(flash_host_pkg::OP_RESUME):
				cyc_wdata = {8'h00, `CMD_RESUME}; // RQ6 RQ20
			4'(flash_host_pkg::OP_CFI):
			begin
				cyc_addr = {a_r[`ADDR_W-1:`BANK_LSB], {(`BANK_LSB-12){1'b0}}, `CFI_ADDR};
				cyc_wdata = {8'h00, `CMD_CFI}; // RQ21
			end
			4'(flash_host_pkg::OP_SECTOR_ADD):
			begin
				cyc_addr = {a_r[`ADDR_W-1:`SECTOR_LSB], {`SECTOR_LSB{1'b0}}};
				cyc_wdata = {8'h00, `CMD_SECTOR_ERASE}; // RQ23
			end
			4'(flash_host_pkg::OP_BYPASS_PROGRAM):
			begin
				cyc_addr = a_r;
				cyc_wdata = (step_r == 3'h0) ? {8'h00, `CMD_PROGRAM} : d_r; // RQ22
			end
			4'(flash_host_pkg::OP_BYPASS_ERASE):
				cyc_wdata = (step_r == 3'h0) ? {8'h00, `CMD_ERASE_SETUP} :
					{8'h00, `CMD_CHIP_ERASE}; // RQ22
			4'(flash_host_pkg::OP_BYPASS_EXIT):
				cyc_wdata = (step_r == 3'h0) ? {8'h00, `CMD_AUTOSEL} :
					{8'h00, `CMD_BYPASS_EXIT}; // RQ22
			default:
			begin
			end
		endcase
	end

	always_comb
	begin
		// While erasing only suspend, read and in-window sector add may pass; bypass commands need bypass mode.
		legal = 1'b1;
		if (erasing_r && op_i != 4'(flash_host_pkg::OP_SUSPEND)
			&& op_i != 4'(flash_host_pkg::OP_READ)
			&& !(win_r != 10'h0 && op_i == 4'(flash_host_pkg::OP_SECTOR_ADD)))
			legal = 1'b0; // RQ25 RQ23
		if (op_i == 4'(flash_host_pkg::OP_SECTOR_ADD) && win_r == 10'h0)
			legal = 1'b0; // RQ23
		if (op_i == 4'(flash_host_pkg::OP_RESUME) && !esusp_r && !psusp_r)
			legal = 1'b0; // RQ6 RQ20
		if ((op_i == 4'(flash_host_pkg::OP_BYPASS_PROGRAM)
			|| op_i == 4'(flash_host_pkg::OP_BYPASS_ERASE)
			|| op_i == 4'(flash_host_pkg::OP_BYPASS_EXIT)) != byp_r
			&& op_i != 4'(flash_host_pkg::OP_READ) && op_i != 4'(flash_host_pkg::OP_CFI)
			&& op_i != 4'(flash_host_pkg::OP_RESET) && op_i != 4'(flash_host_pkg::OP_SUSPEND))
			legal = 1'b0; // RQ22
		if (op_i > 4'(flash_host_pkg::OP_SECTOR_ADD))
			legal = 1'b0;
	end

	always_comb
	begin
		st_nxt = st_r;
		op_nxt = op_r;
		step_nxt = step_r;
		a_nxt = a_r;
		d_nxt = d_r;
		rd_nxt = rd_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		ref_nxt = 1'b0;
		erasing_nxt = erasing_r;
		esusp_nxt = esusp_r;
		psusp_nxt = psusp_r;
		byp_nxt = byp_r;
		win_nxt = (win_r != 10'h0) ? win_r - 10'h1 : 10'h0;
		lat_nxt = lat_r;
		cyc_start = 1'b0;
		case (st_r)
			SEQ_IDLE:
				if (req_i && legal)
				begin
					st_nxt = SEQ_ISSUE;
					op_nxt = op_i;
					a_nxt = addr_i;
					d_nxt = data_i;
					step_nxt = 3'h0;
					busy_nxt = 1'b1;
				end
				else if (req_i)
					ref_nxt = 1'b1;
			SEQ_ISSUE:
			begin
				cyc_start = 1'b1;
				st_nxt = SEQ_WAIT;
			end
			SEQ_WAIT:
				if (cyc_done)
				begin
					rd_nxt = cyc_rdata;
					if (step_r + 3'h1 < n_steps)
					begin
						step_nxt = step_r + 3'h1;
						st_nxt = SEQ_ISSUE;
					end
					else
					begin
						st_nxt = SEQ_IDLE;
						busy_nxt = 1'b0;
						done_nxt = 1'b1;
						case (op_r)
							4'(flash_host_pkg::OP_SECTOR_ERASE), 4'(flash_host_pkg::OP_SECTOR_ADD):
							begin
								erasing_nxt = 1'b1;
								win_nxt = 10'(WIN_CYC); // RQ23
							end
							4'(flash_host_pkg::OP_SUSPEND):
							begin
								if (erasing_r)
								begin
									erasing_nxt = 1'b0;
									esusp_nxt = 1'b1;
									win_nxt = 10'h0; // RQ24
									if (win_r == 10'h0)
									begin
										st_nxt = SEQ_LATENCY;
										busy_nxt = 1'b1;
										done_nxt = 1'b0;
										lat_nxt = 9'(LAT_CYC); // RQ24
									end
								end
								else
									psusp_nxt = 1'b1; // RQ1 RQ3
							end
							4'(flash_host_pkg::OP_RESUME):
								if (psusp_r)
									psusp_nxt = 1'b0; // RQ6 RQ7
								else
								begin
									esusp_nxt = 1'b0;
									erasing_nxt = 1'b1;
								end
							4'(flash_host_pkg::OP_BYPASS_ENTER): byp_nxt = 1'b1;
							4'(flash_host_pkg::OP_BYPASS_EXIT): byp_nxt = 1'b0;
							default:
							begin
							end
						endcase
					end
				end
			default:
				if (lat_r == 9'h0)
				begin
					st_nxt = SEQ_IDLE;
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
				end
				else
					lat_nxt = lat_r - 9'h1;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r <= SEQ_IDLE;
			op_r <= 4'h0;
			step_r <= 3'h0;
			a_r <= '0;
			d_r <= '0;
			rd_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			ref_r <= 1'b0;
			erasing_r <= 1'b0;
			esusp_r <= 1'b0;
			psusp_r <= 1'b0;
			byp_r <= 1'b0;
			win_r <= 10'h0;
			lat_r <= 9'h0;
			win_open_r <= 1'b0;
			accelerate_protect_pin_o <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			step_r <= step_nxt;
			a_r <= a_nxt;
			d_r <= d_nxt;
			rd_r <= rd_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			ref_r <= ref_nxt;
			erasing_r <= erasing_nxt;
			esusp_r <= esusp_nxt;
			psusp_r <= psusp_nxt;
			byp_r <= byp_nxt;
			win_r <= win_nxt;
			lat_r <= lat_nxt;
			win_open_r <= (win_nxt != 10'h0);
			// Held high for the whole bypass period, not only around each command.
			accelerate_protect_pin_o <= byp_nxt; // RQ22
		end
	end

	assign busy_o = busy_r;
	assign done_o = done_r;
	assign refused_o = ref_r;
	assign rdata_o = rd_r;
	assign erasing_o = erasing_r;
	assign erase_susp_o = esusp_r;
	assign prog_susp_o = psusp_r;
	assign bypass_o = byp_r;
	assign window_open_o = win_open_r;
endmodule // flash_cmd_host
`default_nettype wire

// ===== flash_cmd_host_chk.sv
// Concurrent checks on the ports of the flash command host.
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_defines.svh"
module flash_cmd_host_chk
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Command request.
	input wire logic req_i,
	input wire logic [3:0] op_i,
	input wire logic busy_o,
	input wire logic refused_o,
	// State view.
	input wire logic erasing_o,
	input wire logic erase_susp_o,
	input wire logic prog_susp_o,
	input wire logic bypass_o,
	input wire logic window_open_o,
	// Flash pins.
	input wire logic [`ADDR_W-1:0] flash_addr_o,
	input wire logic [`DATA_W-1:0] flash_dq_o,
	input wire logic flash_dq_oe_o,
	input wire logic chip_sel_n_o,
	input wire logic write_n_o,
	input wire logic read_n_o,
	input wire logic accelerate_protect_pin_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic take;
	assign take = req_i && !busy_o;
	sequence write_pulse;
		(!write_n_o)[*4] ##1 write_n_o;
	endsequence
	sequence refusal;
		##[1:2] refused_o;
	endsequence
	a_strobe_width: assert property ($fell(write_n_o) |-> write_pulse)
		else $error("write strobe width wrong");
	a_strobe_select: assert property (!write_n_o || !read_n_o |-> !chip_sel_n_o)
		else $error("strobe without chip select");
	a_write_held: assert property (!write_n_o && $past(!write_n_o)
		|-> $stable(flash_addr_o) && $stable(flash_dq_o) && flash_dq_oe_o)
		else $error("write address or data moved");
	a_read_released: assert property (!read_n_o |-> !flash_dq_oe_o && write_n_o)
		else $error("data bus driven during read");
	a_resume_refused: assert property (take && op_i == flash_host_pkg::OP_RESUME
		&& !erase_susp_o && !prog_susp_o |-> refusal)
		else $error("resume without suspend taken");
	a_erase_locked: assert property (take && erasing_o && !erase_susp_o
		&& op_i != flash_host_pkg::OP_SUSPEND && op_i != flash_host_pkg::OP_READ
		&& !(op_i == flash_host_pkg::OP_SECTOR_ADD && window_open_o) |-> refusal)
		else $error("command taken during erase");
	a_susp_ends_window: assert property (erase_susp_o |-> !window_open_o)
		else $error("erase window open while suspended");
	a_bypass_pin: assert property (bypass_o |-> accelerate_protect_pin_o)
		else $error("accelerate pin low in bypass");
	a_bypass_only: assert property (take && !bypass_o
		&& (op_i == flash_host_pkg::OP_BYPASS_PROGRAM || op_i == flash_host_pkg::OP_BYPASS_EXIT)
		|-> refusal)
		else $error("bypass command outside bypass");
endmodule // flash_cmd_host_chk
bind flash_cmd_host flash_cmd_host_chk u_chk (.*);
`default_nettype wire

// ===== flash_dev_model.sv
// Behavioural model of the flash device.
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model
#(
	parameter logic [15:0] MANUF_CODE = 16'h00c5, // Arbitrary value.
	parameter logic [47:0] PART_CODES = 48'h1a03_1a02_1a01, // Arbitrary value.
	parameter logic [15:0] LOCK_WORD = 16'h00c0,
	parameter logic [10:0] PROT_SECTOR = 11'h401,
	parameter logic [15:0] CFI_WORD = 16'h0051,
	parameter int PROG_NS = 20000
)
(
	// Hardware reset.
	input wire logic hw_rst_i,
	// Bus from the host.
	input wire logic [22:0] addr_i,
	input wire logic [15:0] dq_i,
	input wire logic dq_oe_i,
	input wire logic chip_sel_n_i,
	input wire logic write_n_i,
	input wire logic read_n_i,
	input wire logic accel_i,
	// Data back to the host.
	output logic [15:0] dq_o
);
	logic [15:0] mem [logic [22:0]];
	logic [22:0] wa, pa, as_bank;
	logic [15:0] pw, rd, last;
	logic [2:0] seq;
	logic [1:0] bst;
	logic auto, cfi, byp, pgm_next, prog, psusp, erase, esusp;
	int left;
	function automatic logic [15:0] word_at(input logic [22:0] a);
		if (cfi)
			return CFI_WORD;
		if (auto && a[22:20] == as_bank[22:20])
			case (a[7:0])
				8'h00: return MANUF_CODE;
				8'h01: return PART_CODES[15:0];
				8'h0e: return PART_CODES[31:16];
				8'h0f: return PART_CODES[47:32];
				8'h02: return {15'h0, a[22:12] == PROT_SECTOR};
				8'h03: return LOCK_WORD;
				default: ;
			endcase
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction
	task automatic hw_reset;
		{seq, bst, auto, cfi, byp, pgm_next, prog, psusp, erase, esusp} = '0;
		rd = 16'h0;
		last = 16'h0;
	endtask
	// A released bus shows the inverse of the last word.
	assign dq_o = (!chip_sel_n_i && !read_n_i && !dq_oe_i) ? rd : ~last;
	always @(negedge read_n_i) rd = word_at(addr_i);
	always @(posedge read_n_i) last = rd;
	initial hw_reset();
	always @(posedge hw_rst_i) hw_reset();
	always #100 if (prog && !psusp && !hw_rst_i)
	begin
		if (left == 0)
			{mem[pa], prog} = {pw, 1'b0};
		else
			left = left - 1;
	end
	always @(negedge write_n_i) if (!chip_sel_n_i) wa = addr_i;
	always @(posedge write_n_i) if (!chip_sel_n_i) step(wa, dq_i);
	task automatic step(input logic [22:0] a, input logic [15:0] d);
		logic [11:0] lo;
		logic [7:0] c;
		lo = a[11:0];
		c = d[7:0];
		if (pgm_next)
			{pa, pw, prog, left, pgm_next} = {a, d, 1'b1, PROG_NS / 100, 1'b0};
		else if (erase && !esusp)
			esusp = (c == 8'hb0);
		else if (c == 8'hb0 && prog)
			psusp = 1'b1;
		else if (prog && !psusp)
			;
		else if (c == 8'h30 && seq != 3'd5 && (psusp || esusp))
			{psusp, esusp} = psusp ? {1'b0, esusp} : 2'b00;
		else if (c == 8'hf0)
			{auto, cfi, seq} = '0;
		else if (c == 8'h98 && (byp || lo[7:0] == 8'h55))
			cfi = 1'b1;
		else if (byp)
		begin
			if (bst == 2'd1 && c == 8'h10)
				mem.delete();
			if (bst == 2'd2 && c == 8'h00)
				byp = 1'b0;
			pgm_next = (c == 8'ha0) && accel_i;
			bst = (c == 8'h80) ? 2'd1 : (c == 8'h90) ? 2'd2 : 2'd0;
		end
		else case (seq)
			3'd0, 3'd3: seq = (lo == 12'h555 && c == 8'haa) ? seq + 3'd1 : 3'd0;
			3'd1, 3'd4: seq = (lo == 12'h2aa && c == 8'h55) ? seq + 3'd1 : 3'd0;
			3'd2:
			begin
				seq = (c == 8'h80) ? 3'd3 : 3'd0;
				if (c == 8'h90)
					{auto, as_bank} = {1'b1, a};
				pgm_next = (c == 8'ha0);
				byp = (c == 8'h20);
			end
			default:
			begin
				seq = 3'd0;
				if (c == 8'h10 && lo == 12'h555)
					mem.delete();
				erase = (c == 8'h30);
			end
		endcase
	endtask
endmodule // flash_dev_model
`default_nettype wire

// ===== test_flash_command_decoder_suspend.sv
// Self-checking bench for the flash command host.
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_defines.svh"
module test_flash_command_decoder_suspend;
	localparam logic [15:0] MANUF = 16'h00c5; // Arbitrary value.
	localparam logic [47:0] PARTS = 48'h1a03_1a02_1a01; // Arbitrary value.
	localparam logic [22:0] A1 = 23'h012345, A2 = 23'h0230a0, A3 = 23'h7000f0, A4 = 23'h054321;
	logic clk_i = 1'b0, rst_i, req_i, busy_o, done_o, refused_o, ok;
	logic erasing_o, erase_susp_o, prog_susp_o, bypass_o, window_open_o, flash_dq_oe_o;
	logic chip_sel_n_o, write_n_o, read_n_o, accelerate_protect_pin_o;
	logic [3:0] op_i;
	logic [`ADDR_W-1:0] addr_i, flash_addr_o;
	logic [`DATA_W-1:0] data_i, rdata_o, flash_dq_o, flash_dq_i;
	int fails, checks_done;
	flash_cmd_host u_dut (.*);
	flash_dev_model #(.MANUF_CODE(MANUF), .PART_CODES(PARTS)) u_dev (.hw_rst_i(rst_i),
		.addr_i(flash_addr_o), .dq_i(flash_dq_o), .dq_oe_i(flash_dq_oe_o), .dq_o(flash_dq_i),
		.chip_sel_n_i(chip_sel_n_o), .write_n_i(write_n_o), .read_n_i(read_n_o),
		.accel_i(accelerate_protect_pin_o));
	always #50 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////////
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk16({15'h0, got}, {15'h0, exp});
	endtask
	task automatic run(input logic [3:0] op, input logic [22:0] a, input logic [15:0] d);
		int n = 0;
		{req_i, op_i, addr_i, data_i} = {1'b1, op, a, d};
		@(negedge clk_i);
		req_i = 1'b0;
		while (done_o !== 1'b1 && refused_o !== 1'b1 && n < 1000)
		begin
			@(negedge clk_i);
			n++;
		end
		ok = (done_o === 1'b1);
		chk1(n < 1000, 1'b1);
		@(negedge clk_i);
	endtask
	task automatic req(input logic [3:0] op, input logic [22:0] a, input logic [15:0] d,
		input logic exp_ok);
		run(op, a, d);
		chk1(ok, exp_ok);
	endtask
	task automatic rd(input logic [3:0] op, input logic [22:0] a, input logic [15:0] exp);
		run(op, a, 16'h0);
		chk16(rdata_o, exp);
	endtask
	task automatic settle;
		repeat (260) @(negedge clk_i);
	endtask
	task automatic do_reset;
		rst_i = 1'b1;
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_program_read;
		req(flash_host_pkg::OP_PROGRAM, A1, 16'ha5c3, 1'b1);
		settle();
		rd(flash_host_pkg::OP_READ, A1, 16'ha5c3);
		req(4'hf, A1, 16'h0, 1'b0);
		req(flash_host_pkg::OP_RESUME, A1, 16'h0, 1'b0);
	endtask
	task automatic t_autoselect;
		logic [7:0] offs [3] = '{8'h01, 8'h0e, 8'h0f};
		req(flash_host_pkg::OP_AUTOSEL, 23'h400000, 16'h0, 1'b1);
		rd(flash_host_pkg::OP_AUTOSEL_READ, 23'h400000, MANUF);
		for (int i = 0; i < 3; i++)
			rd(flash_host_pkg::OP_AUTOSEL_READ, {15'h4000, offs[i]}, PARTS[16*i+:16]);
		rd(flash_host_pkg::OP_AUTOSEL_READ, 23'h401002, 16'h0001);
		rd(flash_host_pkg::OP_AUTOSEL_READ, 23'h402002, 16'h0000);
		rd(flash_host_pkg::OP_AUTOSEL_READ, 23'h400003, 16'h00c0);
		req(flash_host_pkg::OP_CFI, 23'h400055, 16'h0, 1'b1);
		rd(flash_host_pkg::OP_READ, 23'h400010, 16'h0051);
		req(flash_host_pkg::OP_RESET, 23'h0, 16'h0, 1'b1);
		rd(flash_host_pkg::OP_READ, A1, 16'ha5c3);
	endtask
	task automatic t_prog_suspend;
		req(flash_host_pkg::OP_PROGRAM, A2, 16'h3c5a, 1'b1);
		req(flash_host_pkg::OP_SUSPEND, A2, 16'h0, 1'b1);
		chk1(prog_susp_o, 1'b1);
		rd(flash_host_pkg::OP_READ, A1, 16'ha5c3);
		req(flash_host_pkg::OP_AUTOSEL, A2, 16'h0, 1'b1);
		rd(flash_host_pkg::OP_AUTOSEL_READ, {A2[22:8], 8'h00}, MANUF);
		req(flash_host_pkg::OP_RESET, 23'h0, 16'h0, 1'b1);
		chk1(prog_susp_o, 1'b1);
		req(flash_host_pkg::OP_RESUME, A2, 16'h0, 1'b1);
		req(flash_host_pkg::OP_RESUME, A2, 16'h0, 1'b0);
		req(flash_host_pkg::OP_SUSPEND, A2, 16'h0, 1'b1);
		chk1(prog_susp_o, 1'b1);
		req(flash_host_pkg::OP_RESUME, A2, 16'h0, 1'b1);
		settle();
		rd(flash_host_pkg::OP_READ, A2, 16'h3c5a);
	endtask
	task automatic t_erase;
		req(flash_host_pkg::OP_SECTOR_ERASE, A2, 16'h0, 1'b1);
		chk1(window_open_o, 1'b1);
		req(flash_host_pkg::OP_SECTOR_ADD, A3, 16'h0, 1'b1);
		req(flash_host_pkg::OP_PROGRAM, A1, 16'h1111, 1'b0);
		req(flash_host_pkg::OP_SUSPEND, A2, 16'h0, 1'b1);
		chk1(erase_susp_o, 1'b1);
		chk1(window_open_o, 1'b0);
		rd(flash_host_pkg::OP_READ, A1, 16'ha5c3);
		req(flash_host_pkg::OP_PROGRAM, A4, 16'h0f0f, 1'b1);
		req(flash_host_pkg::OP_SUSPEND, A4, 16'h0, 1'b1);
		chk1(prog_susp_o, 1'b1);
		req(flash_host_pkg::OP_RESUME, A4, 16'h0, 1'b1);
		settle();
		rd(flash_host_pkg::OP_READ, A4, 16'h0f0f);
		req(flash_host_pkg::OP_RESUME, A2, 16'h0, 1'b1);
		chk1(erase_susp_o, 1'b0);
		repeat (600) @(negedge clk_i);
		req(flash_host_pkg::OP_SECTOR_ADD, A3, 16'h0, 1'b0);
		req(flash_host_pkg::OP_SUSPEND, A2, 16'h0, 1'b1);
		chk1(erase_susp_o, 1'b1);
		do_reset();
	endtask
	task automatic t_bypass;
		req(flash_host_pkg::OP_BYPASS_PROGRAM, A3, 16'h7e81, 1'b0);
		req(flash_host_pkg::OP_BYPASS_ENTER, A3, 16'h0, 1'b1);
		chk1(accelerate_protect_pin_o, 1'b1);
		req(flash_host_pkg::OP_PROGRAM, A3, 16'h7e81, 1'b0);
		req(flash_host_pkg::OP_BYPASS_PROGRAM, A3, 16'h7e81, 1'b1);
		settle();
		req(flash_host_pkg::OP_BYPASS_EXIT, A3, 16'h0, 1'b1);
		chk1(bypass_o, 1'b0);
		rd(flash_host_pkg::OP_READ, A3, 16'h7e81);
		req(flash_host_pkg::OP_CHIP_ERASE, 23'h0, 16'h0, 1'b1);
		rd(flash_host_pkg::OP_READ, A3, 16'hffff);
		do_reset();
		req(flash_host_pkg::OP_BYPASS_ENTER, A1, 16'h0, 1'b1);
		req(flash_host_pkg::OP_BYPASS_ERASE, A1, 16'h0, 1'b1);
		chk1(erasing_o, 1'b0);
		do_reset();
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		{rst_i, req_i, op_i, addr_i, data_i, fails, checks_done} = '0;
		do_reset();
		t_program_read();
		t_autoselect();
		t_prog_suspend();
		t_erase();
		t_bypass();
		report_and_stop();
	end
	// About 2800 cycles are needed; allow 30000.
	initial
	begin
		#3000000;
		fails++;
		report_and_stop();
	end
endmodule // test_flash_command_decoder_suspend
`default_nettype wire
